// ### design/icmc_pkg.sv
// Package: register map, field layout, reset values and types
package icmc_pkg;

  localparam logic [7:0]  ICMC_ADDR_DEVCTL  = 8'h1a;
  localparam logic [7:0]  ICMC_ADDR_SCANCTL = 8'h1b;

  // Device control field positions
  localparam int ICMC_DC_CHAN_HI  = 15;
  localparam int ICMC_DC_CHAN_LO  = 14;
  localparam int ICMC_DC_SLEEP    = 13;
  localparam int ICMC_DC_OVERRIDE = 12;
  localparam int ICMC_DC_STARTUP  = 11;
  localparam int ICMC_DC_AMPOFF   = 10;
  localparam int ICMC_DC_REFSEL   = 9;
  localparam int ICMC_DC_IRQMASK  = 7;
  localparam int ICMC_DC_BOOST    = 6;

  // Scan control field positions
  localparam int ICMC_SC_SCAN_EN  = 15;
  localparam int ICMC_SC_LIST_HI  = 14;
  localparam int ICMC_SC_LIST_LO  = 13;
  localparam int ICMC_SC_FILT_HI  = 2;
  localparam int ICMC_SC_FILT_LO  = 0;

  // Reset images; reserved bits carry their documented values
  localparam logic [15:0] ICMC_DEVCTL_RST  = 16'h2801;
  localparam logic [15:0] ICMC_SCANCTL_RST = 16'h020f;

  // Scan lists
  localparam logic [1:0] ICMC_LIST_01   = 2'h0;
  localparam logic [1:0] ICMC_LIST_012  = 2'h1;
  localparam logic [1:0] ICMC_LIST_0123 = 2'h2;
  localparam logic [1:0] ICMC_LIST_01B  = 2'h3;

  // Filter bandwidth codes
  localparam logic [2:0] ICMC_FILT_1M0  = 3'h1;
  localparam logic [2:0] ICMC_FILT_3M3  = 3'h4;
  localparam logic [2:0] ICMC_FILT_10M  = 3'h5;
  localparam logic [2:0] ICMC_FILT_33M  = 3'h7;

  localparam logic [1:0] ICMC_CH0 = 2'h0;
  localparam logic [4:0] ICMC_DRIVE_ZERO = 5'h00;

  typedef enum logic [3:0] {
    ICMC_BW_1M0 = 4'h1,
    ICMC_BW_3M3 = 4'h2,
    ICMC_BW_10M = 4'h4,
    ICMC_BW_33M = 4'h8
  } icmc_bw_t;

  // Control bundle handed to the conversion core
  typedef struct packed {
    logic       active;
    logic [1:0] channel;
    logic       drive_override_enable;
    logic       startup_drive_select;
    logic       amplitude_correction_off;
    logic       reference_source_select;
    logic       boost_drive_ch0;
    icmc_bw_t   filter_bw;
  } icmc_ctrl_t;

  // Register write/read port
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } icmc_req_t;

endpackage : icmc_pkg

// ### design/icmc_scan_seq.sv
// Channel sequencer: picks the channel for each next conversion
`timescale 1ns/10ps
`default_nettype none
module icmc_scan_seq
  import icmc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic       conv_done,
  input  wire logic       scan_en,
  input  wire logic [1:0] list_sel,
  input  wire logic [1:0] single_chan,
  input  wire logic       four_ch,
  output var  logic [1:0] next_chan
);

  function automatic logic [1:0] last_of(input logic [1:0] sel,
                                         input logic       four);
    logic [1:0] l;
    l = 2'h1;
    if (four && sel == ICMC_LIST_012)
      l = 2'h2;
    else if (four && sel == ICMC_LIST_0123)
      l = 2'h3;
    return l;
  endfunction : last_of

  logic [1:0] pos_reg;
  logic [1:0] pos_next;
  wire  [1:0] last_w = last_of(list_sel, four_ch);
  wire        wrap_w = (pos_reg >= last_w);

  // Position advances only at a conversion boundary, so edits land next time
  assign pos_next = !run || !scan_en ? ICMC_CH0 :
                    !conv_done ? (pos_reg > last_w ? ICMC_CH0 : pos_reg) :
                    wrap_w ? ICMC_CH0 : pos_reg + 2'h1;

  always_ff @(posedge core_clk)
  begin
    if (rst)
      pos_reg <= ICMC_CH0;
    else
      pos_reg <= pos_next;
  end

  // Channels 2/3 fold onto 0/1 on the two-channel variant
  assign next_chan = scan_en ? pos_reg :
                     (four_ch ? single_chan : {1'b0, single_chan[0]});

endmodule : icmc_scan_seq
`default_nettype wire

// ### design/icmc_drive_track.sv
// Measured drive level store, refreshed after amplitude correction
`timescale 1ns/10ps
`default_nettype none
module icmc_drive_track
  import icmc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       amp_phase_done,
  input  wire logic [1:0] amp_chan,
  input  wire logic [4:0] amp_level,
  input  wire logic       correction_off,
  output var  logic [19:0] levels
);

  logic [4:0] lvl_reg [4];

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_ch
      wire hit_w = amp_phase_done && !correction_off &&
                   (amp_chan == 2'(g));
      always_ff @(posedge core_clk)
      begin
        if (rst)
          lvl_reg[g] <= ICMC_DRIVE_ZERO;
        else if (hit_w)
          lvl_reg[g] <= amp_level;
      end
      assign levels[g*5 +: 5] = lvl_reg[g];
    end
  endgenerate

endmodule : icmc_drive_track
`default_nettype wire

// ### design/icmc_mode_ctrl.sv
// Top: configuration registers and conversion sequencing control
`timescale 1ns/10ps
`default_nettype none
module icmc_mode_ctrl
  import icmc_pkg::*;
#(
  parameter bit FOUR_CHANNEL = 1'b1
)
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire icmc_req_t   reg_req,
  output logic [15:0]      reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        status_update,
  input  wire logic        status_clear,
  input  wire logic        conv_done,
  input  wire logic        amp_phase_done,
  input  wire logic [1:0]  amp_chan,
  input  wire logic [4:0]  amp_level,
  output icmc_ctrl_t       ctrl,
  output logic [19:0]      measured_drive_level,
  output logic             boost_misuse,
  output logic             irq_n_pin
);

  logic [15:0] devctl_reg;
  logic [15:0] scanctl_reg;
  logic [15:0] rdata_reg;
  logic        rvalid_reg;
  logic        irq_n_reg;
  icmc_ctrl_t  ctrl_reg;
  icmc_ctrl_t  ctrl_next;
  logic [1:0]  seq_chan;
  logic [19:0] lvl_w;
  logic [19:0] lvl_reg;
  logic        misuse_reg;

  function automatic icmc_bw_t filt_decode(input logic [2:0] code);
    icmc_bw_t b;
    b = ICMC_BW_33M;
    if (code == ICMC_FILT_1M0)
      b = ICMC_BW_1M0;
    else if (code == ICMC_FILT_3M3)
      b = ICMC_BW_3M3;
    else if (code == ICMC_FILT_10M)
      b = ICMC_BW_10M;
    return b;
  endfunction : filt_decode

  wire hit_dc_w = (reg_req.addr == ICMC_ADDR_DEVCTL);
  wire hit_sc_w = (reg_req.addr == ICMC_ADDR_SCANCTL);
  wire wr_dc_w  = reg_req.wr && hit_dc_w;
  wire wr_sc_w  = reg_req.wr && hit_sc_w;
  wire [15:0] rd_mux_w = hit_dc_w ? devctl_reg :
                         hit_sc_w ? scanctl_reg : 16'h0000;

  wire scan_en_w  = scanctl_reg[ICMC_SC_SCAN_EN];
  wire [1:0] list_w = scanctl_reg[ICMC_SC_LIST_HI:ICMC_SC_LIST_LO];
  wire [1:0] chan_w = devctl_reg[ICMC_DC_CHAN_HI:ICMC_DC_CHAN_LO];
  wire active_w   = !devctl_reg[ICMC_DC_SLEEP];
  wire mask_w     = devctl_reg[ICMC_DC_IRQMASK];

  // Registers store every bit as written; reserved bits read back
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      devctl_reg  <= ICMC_DEVCTL_RST;
      scanctl_reg <= ICMC_SCANCTL_RST;
    end
    else
    begin
      if (wr_dc_w)
        devctl_reg <= reg_req.wdata;
      if (wr_sc_w)
        scanctl_reg <= reg_req.wdata;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rdata_reg  <= reg_req.rd ? rd_mux_w : rdata_reg;
      rvalid_reg <= reg_req.rd;
    end
  end

  icmc_scan_seq u_seq (
    .core_clk    (core_clk),
    .rst         (rst),
    .run         (active_w),
    .conv_done   (conv_done),
    .scan_en     (scan_en_w),
    .list_sel    (list_w),
    .single_chan (chan_w),
    .four_ch     (FOUR_CHANNEL),
    .next_chan   (seq_chan)
  );

  icmc_drive_track u_trk (
    .core_clk       (core_clk),
    .rst            (rst),
    .amp_phase_done (amp_phase_done),
    .amp_chan       (amp_chan),
    .amp_level      (amp_level),
    .correction_off (devctl_reg[ICMC_DC_AMPOFF]),
    .levels         (lvl_w)
  );

  // Channel is latched only at a conversion boundary or while asleep
  wire take_chan_w = conv_done || !ctrl_reg.active;

  always_comb
  begin
    ctrl_next = ctrl_reg;
    ctrl_next.active = active_w;
    ctrl_next.channel = take_chan_w ? seq_chan : ctrl_reg.channel;
    ctrl_next.drive_override_enable =
      devctl_reg[ICMC_DC_OVERRIDE];
    ctrl_next.startup_drive_select =
      devctl_reg[ICMC_DC_STARTUP];
    ctrl_next.amplitude_correction_off =
      devctl_reg[ICMC_DC_AMPOFF];
    ctrl_next.reference_source_select =
      devctl_reg[ICMC_DC_REFSEL];
    // Boost only reaches the drive while channel 0 is being converted
    ctrl_next.boost_drive_ch0 = devctl_reg[ICMC_DC_BOOST] &&
      (ctrl_next.channel == ICMC_CH0);
    ctrl_next.filter_bw = filt_decode(
      scanctl_reg[ICMC_SC_FILT_HI:ICMC_SC_FILT_LO]);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      // Flag fields derived from the register reset image so the two cannot drift
      ctrl_reg.active                   <= !ICMC_DEVCTL_RST[ICMC_DC_SLEEP];
      ctrl_reg.channel                  <= ICMC_CH0;
      ctrl_reg.drive_override_enable    <= ICMC_DEVCTL_RST[ICMC_DC_OVERRIDE];
      ctrl_reg.startup_drive_select     <= ICMC_DEVCTL_RST[ICMC_DC_STARTUP];
      ctrl_reg.amplitude_correction_off <= ICMC_DEVCTL_RST[ICMC_DC_AMPOFF];
      ctrl_reg.reference_source_select  <= ICMC_DEVCTL_RST[ICMC_DC_REFSEL];
      ctrl_reg.boost_drive_ch0          <= ICMC_DEVCTL_RST[ICMC_DC_BOOST];
      ctrl_reg.filter_bw                <= ICMC_BW_33M;
    end
    else
      ctrl_reg <= ctrl_next;
  end

  // Pin held low from a status update until cleared or masked; set beats clear
  always_ff @(posedge core_clk)
  begin
    if (rst)
      irq_n_reg <= 1'b1;
    else if (mask_w)
      irq_n_reg <= 1'b1;
    else if (status_update)
      irq_n_reg <= 1'b0;
    else if (status_clear)
      irq_n_reg <= 1'b1;
  end

  // Flag only; boost with scanning is the host's fault, not blocked here
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      misuse_reg <= 1'b0;
      lvl_reg    <= 20'h00000;
    end
    else
    begin
      misuse_reg <= devctl_reg[ICMC_DC_BOOST] && scan_en_w;
      lvl_reg    <= lvl_w;
    end
  end

  assign reg_rdata            = rdata_reg;
  assign reg_rvalid           = rvalid_reg;
  assign ctrl                 = ctrl_reg;
  assign measured_drive_level = lvl_reg;
  assign boost_misuse         = misuse_reg;
  assign irq_n_pin            = irq_n_reg;

endmodule : icmc_mode_ctrl
`default_nettype wire

// ### verif/icmc_mode_ctrl_checker.sv
// Checker: port relations of the mode control block
`timescale 1ns/10ps
`default_nettype none
module icmc_mode_ctrl_checker
  import icmc_pkg::*;
#(
  parameter bit FOUR_CHANNEL = 1'b1
)
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire icmc_req_t   reg_req,
  input wire logic        reg_rvalid,
  input wire logic        status_update,
  input wire logic        status_clear,
  input wire logic        conv_done,
  input wire logic        amp_phase_done,
  input wire icmc_ctrl_t  ctrl,
  input wire logic [19:0] measured_drive_level,
  input wire logic        irq_n_pin
);
  default clocking cb_main @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_answer;
    ##1 reg_rvalid;
  endsequence
  sequence s_frozen;
    ##2 $stable(measured_drive_level);
  endsequence
  a_read_answer: assert property (reg_req.rd |-> s_answer)
    else $error("read not answered");
  a_rvalid_lone: assert property (!reg_req.rd |=> !reg_rvalid)
    else $error("answer without read");
  a_reset_image: assert property ($past(rst) |-> !ctrl.active &&
    ctrl.startup_drive_select && ctrl.filter_bw == ICMC_BW_33M && irq_n_pin)
    else $error("control not at reset image");
  a_chan_hold: assert property ($changed(ctrl.channel) |->
    $past(conv_done) || !$past(ctrl.active))
    else $error("channel moved mid conversion");
  a_chan_range: assert property (ctrl.channel <=
    (FOUR_CHANNEL ? 2'h3 : 2'h1))
    else $error("channel outside variant");
  a_irq_cause: assert property ($fell(irq_n_pin) |->
    $past(status_update))
    else $error("irq without status update");
  a_irq_release: assert property (status_clear && !status_update
    |=> irq_n_pin)
    else $error("irq not released");
  a_boost_ch0: assert property (ctrl.boost_drive_ch0 |->
    ctrl.channel == ICMC_CH0)
    else $error("boost off channel 0");
  a_level_cause: assert property ($changed(measured_drive_level) |->
    $past(amp_phase_done, 2))
    else $error("level changed without correction");
  a_level_frozen: assert property (ctrl.amplitude_correction_off &&
    amp_phase_done |-> s_frozen)
    else $error("level updated while frozen");
endmodule : icmc_mode_ctrl_checker
bind icmc_mode_ctrl icmc_mode_ctrl_checker #(.FOUR_CHANNEL(FOUR_CHANNEL))
  u_chk (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
  .reg_rvalid(reg_rvalid), .status_update(status_update),
  .status_clear(status_clear), .conv_done(conv_done),
  .amp_phase_done(amp_phase_done), .ctrl(ctrl),
  .measured_drive_level(measured_drive_level), .irq_n_pin(irq_n_pin));
`default_nettype wire

// ### verif/icmc_host_model.sv
// Host model: register writes and reads into the block
`timescale 1ns/10ps
`default_nettype none
module icmc_host_model
  import icmc_pkg::*;
(
  input  wire logic      core_clk,
  output var  icmc_req_t reg_req
);
  logic scan_reg = 1'b0;
  logic boost_reg = 1'b0;
  initial reg_req = '0;
  // Reserved bits are forced here whatever the caller passes
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
    logic [15:0] v;
    v = d;
    if (w && a == ICMC_ADDR_DEVCTL)
    begin
      v = (v & 16'hfec0) | 16'h0001;
      v[ICMC_DC_BOOST] = d[ICMC_DC_BOOST] & ~scan_reg;
      boost_reg = v[ICMC_DC_BOOST];
    end
    if (w && a == ICMC_ADDR_SCANCTL)
    begin
      v = (v & 16'he007) | 16'h0208;
      v[ICMC_SC_SCAN_EN] = d[ICMC_SC_SCAN_EN] & ~boost_reg;
      scan_reg = v[ICMC_SC_SCAN_EN];
    end
    @(posedge core_clk);
    reg_req <= '{w, ~w, a, v};
    @(posedge core_clk);
    reg_req <= '0;
  endtask : xfer
endmodule : icmc_host_model
`default_nettype wire

// ### verif/icmc_mode_ctrl_tb_top.sv
// Self-checking bench for the mode control block
`timescale 1ns/10ps
`default_nettype none
module icmc_mode_ctrl_tb_top;
  import icmc_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  icmc_req_t   reg_req;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic [3:0]  pls = 4'h0;
  logic [1:0]  amp_chan = 2'h0;
  logic [4:0]  amp_level = 5'h00;
  icmc_ctrl_t  ctrl;
  logic [19:0] lvl;
  logic        boost_misuse;
  logic        irq_n_pin;
  logic [15:0] lfsr = 16'h58f6;
  int          error_cnt = 0;
  int          tests_run = 0;
  logic [15:0] exp_q[$];
  wire logic [4:0] cb;
  assign cb = {ctrl.active, ctrl.drive_override_enable,
    ctrl.startup_drive_select, ctrl.amplitude_correction_off,
    ctrl.reference_source_select};
  always #10 core_clk = ~core_clk;
  icmc_mode_ctrl #(.FOUR_CHANNEL(1'b1)) u_dut (.core_clk(core_clk),
    .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .status_update(pls[0]),
    .status_clear(pls[1]), .conv_done(pls[2]), .amp_phase_done(pls[3]),
    .amp_chan(amp_chan), .amp_level(amp_level), .ctrl(ctrl),
    .measured_drive_level(lvl), .boost_misuse(boost_misuse),
    .irq_n_pin(irq_n_pin));
  icmc_host_model u_host (.core_clk(core_clk), .reg_req(reg_req));
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt
  task automatic stop_test();
    if (error_cnt == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [19:0] e,
                     input logic [19:0] s);
    tests_run++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic chk_rd(input logic [19:0] e, input logic [15:0] s);
    chk("rdata", e, 20'(s));
  endtask : chk_rd
  task automatic chk_irq(input string n, input logic e, input logic s);
    chk(n, 20'(e), 20'(s));
  endtask : chk_irq
  task automatic chk_lvl(input logic [4:0] e, input logic [4:0] s);
    chk("level", 20'(e), 20'(s));
  endtask : chk_lvl
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_host.xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    u_host.xfer(1'b0, a, 16'h0000);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic pulse(input logic [3:0] m);
    @(posedge core_clk);
    pls <= m;
    @(posedge core_clk);
    pls <= 4'h0;
    #1;
  endtask : pulse
  always @(posedge core_clk)
    if (reg_rvalid === 1'b1)
      chk_rd(exp_q.size() ? 20'(exp_q.pop_front()) : 20'hfffff,
             reg_rdata);
  initial
  begin
    repeat (50000) @(posedge core_clk);
    error_cnt++;
    stop_test();
  end
  initial
  begin
    logic [15:0] v;
    logic [4:0]  e;
    int          c;
    int          n;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    cyc(0);
    chk("ctl_rst", {ctrl.active, irq_n_pin, ctrl.filter_bw}, 20'h18);
    rd(ICMC_ADDR_DEVCTL, ICMC_DEVCTL_RST);
    rd(ICMC_ADDR_SCANCTL, ICMC_SCANCTL_RST);
    wr(8'h1c, 16'hffff);
    rd(8'h1c, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      lfsr = nxt(lfsr);
      v = (lfsr & 16'hfe80) | 16'h0001;
      wr(ICMC_ADDR_DEVCTL, v);
      cyc(1);
      chk("cfg", {~v[13], v[12:9]}, cb);
      rd(ICMC_ADDR_DEVCTL, v);
    end
    // Pass 3 uses an undefined code, which must fall back to 33 MHz
    for (int i = 0; i < 5; i++)
    begin
      v[2:0] = i == 0 ? ICMC_FILT_1M0 : i == 1 ? ICMC_FILT_3M3 :
               i == 2 ? ICMC_FILT_10M : i == 3 ? 3'h2 : ICMC_FILT_33M;
      wr(ICMC_ADDR_SCANCTL, {13'h0000, v[2:0]});
      cyc(1);
      chk("bw", 20'h1 << (i > 3 ? 3 : i), ctrl.filter_bw);
    end
    wr(ICMC_ADDR_DEVCTL, 16'h0000);
    pulse(4'h4);
    c = 0;
    for (int s = 1; s < 5; s++)
    begin
      wr(ICMC_ADDR_DEVCTL, {s[1:0], 14'h0000});
      cyc(2);
      chk("hold", 20'(c), ctrl.channel);
      pulse(4'h4);
      c = s % 4;
      chk("single", 20'(c), ctrl.channel);
    end
    for (int l = 0; l < 4; l++)
    begin
      n = l == 1 ? 3 : l == 2 ? 4 : 2;
      // Scan off first, so every list starts from its first channel
      wr(ICMC_ADDR_SCANCTL, 16'h0007);
      wr(ICMC_ADDR_SCANCTL, {1'b1, l[1:0], 13'h0007});
      pulse(4'h4);
      c = 0;
      chk("scan0", 20'(c), ctrl.channel);
      for (int k = 0; k < 5; k++)
      begin
        pulse(4'h4);
        c = (c + 1) % n;
        chk("scan", 20'(c), ctrl.channel);
      end
    end
    wr(ICMC_ADDR_SCANCTL, 16'h0007);
    wr(ICMC_ADDR_DEVCTL, 16'h0040);
    pulse(4'h4);
    chk("boost", {ctrl.boost_drive_ch0, boost_misuse}, 20'h2);
    wr(ICMC_ADDR_DEVCTL, 16'h0000);
    pulse(4'h1);
    chk_irq("irq_set", 1'b0, irq_n_pin);
    pulse(4'h2);
    chk_irq("irq_clr", 1'b1, irq_n_pin);
    pulse(4'h3);
    chk_irq("irq_both", 1'b0, irq_n_pin);
    wr(ICMC_ADDR_DEVCTL, 16'h0080);
    pulse(4'h1);
    chk_irq("irq_mask", 1'b1, irq_n_pin);
    for (int i = 0; i < 2; i++)
    begin
      wr(ICMC_ADDR_DEVCTL, i ? 16'h0400 : 16'h0000);
      lfsr = nxt(lfsr);
      if (i == 0)
        e = lfsr[4:0];
      amp_chan <= 2'h2;
      amp_level <= i ? ~e : e;
      pulse(4'h8);
      cyc(2);
      chk_lvl(e, lvl[14:10]);
    end
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(ICMC_ADDR_DEVCTL, ICMC_DEVCTL_RST);
    cyc(3);
    chk("pending", 20'h0, 20'(exp_q.size()));
    stop_test();
  end
endmodule : icmc_mode_ctrl_tb_top
`default_nettype wire
